// ==== core/ppol_cfg.svh ====
// Constants of the port pin override logic: offsets, field positions, reset values.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses on eight address bits.
// Function
// - Sleep clamp forces each pin's digital input to ground before the Schmitt trigger.
// - Pins with their external interrupt enabled bypass the sleep clamp.
// - Clamp release on a high pin sensing rising or any edge sets its interrupt flag at wake-up.
// - All pull-ups stay off while reset is active.
// - Pull-up follows override value, else on when direction 0, latch 1, disable 0.
// - Output enable follows direction override value, else the direction bit.
// - Driven value is the value override when enabled, else the output latch.
// - Toggle override enable inverts the pin's output latch bit.
// - Input enable follows its override value, else normal or sleep state decides.
// - Raw digital input leaves after the Schmitt trigger, before the synchroniser.
// - Each pin offers an analog link wired straight to the pad.
// - Strobes are shared per port, clock, clamp and disable by all, overrides per pin.
// - Without overrides direction one drives the latch, zero inputs with latch pull-up.
// - Global pull-up disable sits at bit 4 of the control register.
// - Pin input passes a clock-high latch then the pin register on the rising edge.
// - All pins tri-state at once when reset becomes active, clock or not.
`ifndef PPOL_CFG_SVH
`define PPOL_CFG_SVH

`define PPOL_PINS 8
`define PPOL_AW 8
`define PPOL_OFS_LATCH 8'h00
`define PPOL_OFS_DIR 8'h04
`define PPOL_OFS_PIN 8'h08
`define PPOL_OFS_MCU 8'h0C
`define PPOL_OFS_STAT 8'h10
`define PPOL_OFS_MASK 8'h14
`define PPOL_OFS_SENSE 8'h18
`define PPOL_PUD_BIT 4
`define PPOL_RST_BYTE 8'h00
`define PPOL_RST_SENSE 16'h0000
`define PPOL_RESP_OKAY 2'h0
`define PPOL_RESP_SLVERR 2'h2

`endif

// ==== core/ppol_pkg.sv ====
// Types of the port pin override logic.
// Assumes the constants header is included by the modules that use it.
package ppol_pkg;

  typedef logic [7:0] ppol_byte_t;

  typedef enum logic [1:0] {
    PPOL_SENSE_NONE = 2'h0,
    PPOL_SENSE_ANY = 2'h1,
    PPOL_SENSE_FALL = 2'h2,
    PPOL_SENSE_RISE = 2'h3
  } ppol_sense_e;

endpackage : ppol_pkg

// ==== core/ppol_sync.sv ====
// Two-stage input synchroniser of the port pins.
// Assumes the pins are sampled on the single reference clock.
`timescale 1ns/1ps
`include "ppol_cfg.svh"
module ppol_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_d,
  output logic [7:0] o_q
);

  logic [7:0] hold_q;

  // The first stage closes at the falling edge, as a latch open while the clock is high.
  always_ff @(negedge i_clk) begin
    if (i_srst) begin
      hold_q <= `PPOL_RST_BYTE;
    end else begin
      hold_q <= i_d;
    end
  end

  // The pin register takes the held value at the next rising edge.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_q <= `PPOL_RST_BYTE;
    end else begin
      o_q <= hold_q;
    end
  end

endmodule : ppol_sync

// ==== core/ppol_top.sv ====
// One eight-pin port with alternate-function overrides and an AXI4-Lite register slave.
// Assumes peripherals drive the override signals synchronously to the reference clock.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ppol_cfg.svh"
module ppol_top (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic [`PPOL_AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [`PPOL_AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_IRQ,
  input wire logic I_SLEEP_CLAMP,
  input wire logic [7:0] I_PAD_IN,
  output logic [7:0] O_PAD_OUT,
  output logic [7:0] O_PAD_OE_N,
  output logic [7:0] O_PAD_PULLUP,
  output logic [7:0] O_RAW_DIGITAL_IN,
  output logic [7:0] O_ANALOG_PAD_LINK,
  input wire logic [7:0] I_PULLUP_OVERRIDE_EN,
  input wire logic [7:0] I_PULLUP_OVERRIDE_VAL,
  input wire logic [7:0] I_DIR_OVERRIDE_EN,
  input wire logic [7:0] I_DIR_OVERRIDE_VAL,
  input wire logic [7:0] I_OUT_VALUE_OVERRIDE_EN,
  input wire logic [7:0] I_OUT_VALUE_OVERRIDE_VAL,
  input wire logic [7:0] I_OUT_TOGGLE_OVERRIDE_EN,
  input wire logic [7:0] I_IN_ENABLE_OVERRIDE_EN,
  input wire logic [7:0] I_IN_ENABLE_OVERRIDE_VAL
);

  // Merges one byte lane of a bus write into a stored byte under its lane strobe.
  function automatic ppol_pkg::ppol_byte_t merge_byte(
    input ppol_pkg::ppol_byte_t old_v,
    input logic [7:0] new_v,
    input logic strb
  );
    merge_byte = strb ? new_v : old_v;
  endfunction : merge_byte

  // Decides whether an edge on one pin matches its sense selection.
  function automatic logic sense_hit(
    input logic [1:0] sense,
    input logic rise,
    input logic fall
  );
    logic hit;
    hit = 1'b0;
    case (sense)
      ppol_pkg::PPOL_SENSE_ANY: hit = rise | fall;
      ppol_pkg::PPOL_SENSE_FALL: hit = fall;
      ppol_pkg::PPOL_SENSE_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
    sense_hit = hit;
  endfunction : sense_hit

  // Checks whether an address names a register of this port.
  function automatic logic addr_hit(input logic [`PPOL_AW-1:0] a);
    addr_hit = (a == `PPOL_OFS_LATCH) || (a == `PPOL_OFS_DIR) || (a == `PPOL_OFS_PIN) ||
               (a == `PPOL_OFS_MCU) || (a == `PPOL_OFS_STAT) || (a == `PPOL_OFS_MASK) ||
               (a == `PPOL_OFS_SENSE);
  endfunction : addr_hit

  ppol_pkg::ppol_byte_t latch_q;
  ppol_pkg::ppol_byte_t latch_d;
  ppol_pkg::ppol_byte_t dir_q;
  ppol_pkg::ppol_byte_t dir_d;
  ppol_pkg::ppol_byte_t status_q;
  ppol_pkg::ppol_byte_t status_d;
  ppol_pkg::ppol_byte_t mask_q;
  ppol_pkg::ppol_byte_t mask_d;
  logic [15:0] sense_q;
  logic [15:0] sense_d;
  logic pud_q;
  logic pud_d;
  logic [7:0] pin_input_reg;
  logic [7:0] pin_prev_q;

  logic aw_held_q;
  logic [`PPOL_AW-1:0] awaddr_q;
  logic w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write channel acceptance: each address and data beat is held until both are in.
  wire aw_take = I_AWVALID & O_AWREADY;
  wire w_take = I_WVALID & O_WREADY;
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_ok = addr_hit(awaddr_q);
  wire wsel_latch = wr_fire & (awaddr_q == `PPOL_OFS_LATCH);
  wire wsel_dir = wr_fire & (awaddr_q == `PPOL_OFS_DIR);
  wire wsel_pin = wr_fire & (awaddr_q == `PPOL_OFS_PIN);
  wire wsel_mcu = wr_fire & (awaddr_q == `PPOL_OFS_MCU);
  wire wsel_stat = wr_fire & (awaddr_q == `PPOL_OFS_STAT);
  wire wsel_mask = wr_fire & (awaddr_q == `PPOL_OFS_MASK);
  wire wsel_sense = wr_fire & (awaddr_q == `PPOL_OFS_SENSE);
  wire [7:0] wbyte0 = wdata_q[7:0];
  wire [7:0] wbyte1 = wdata_q[15:8];

  // Read channel acceptance: one read in flight, answered from registers.
  wire ar_take = I_ARVALID & O_ARREADY;
  wire rd_ok = addr_hit(I_ARADDR);

  assign O_AWREADY = ~aw_held_q & ~bvalid_q;
  assign O_WREADY = ~w_held_q & ~bvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = ~rvalid_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  // Pin toggling by bus write of ones to the pin register and by peripheral request.
  wire [7:0] bus_toggle = wsel_pin & wstrb_q[0] ? wbyte0 : 8'h00;
  wire [7:0] latch_written = wsel_latch ? merge_byte(latch_q, wbyte0, wstrb_q[0]) : latch_q;
  wire [7:0] latch_toggled = latch_written ^ bus_toggle ^ I_OUT_TOGGLE_OVERRIDE_EN;

  // Pad control: each override picks its own field independently.
  wire [7:0] pull_normal = ~dir_q & latch_q & {8{~pud_q}};
  wire [7:0] pull_sel = (I_PULLUP_OVERRIDE_EN & I_PULLUP_OVERRIDE_VAL) |
                        (~I_PULLUP_OVERRIDE_EN & pull_normal);
  wire [7:0] drive_en = (I_DIR_OVERRIDE_EN & I_DIR_OVERRIDE_VAL) |
                        (~I_DIR_OVERRIDE_EN & dir_q);
  wire [7:0] drive_val = (I_OUT_VALUE_OVERRIDE_EN & I_OUT_VALUE_OVERRIDE_VAL) |
                         (~I_OUT_VALUE_OVERRIDE_EN & latch_q);

  // Digital input enable: sleep clamp applies unless the pin's interrupt is enabled.
  wire [7:0] sleep_in_en = ~({8{I_SLEEP_CLAMP}} & ~mask_q);
  wire [7:0] in_en = (I_IN_ENABLE_OVERRIDE_EN & I_IN_ENABLE_OVERRIDE_VAL) |
                     (~I_IN_ENABLE_OVERRIDE_EN & sleep_in_en);
  wire [7:0] clamped_in = I_PAD_IN & in_en;

  // Edge detection on the synchronised pin; a clamp release looks like a rising edge.
  wire [7:0] pin_rise = pin_input_reg & ~pin_prev_q;
  wire [7:0] pin_fall = ~pin_input_reg & pin_prev_q;
  logic [7:0] pin_event;

  always_comb begin
    pin_event = 8'h00;
    for (int i = 0; i < `PPOL_PINS; i++) begin
      pin_event[i] = sense_hit(sense_q[2*i +: 2], pin_rise[i], pin_fall[i]);
    end
  end

  assign O_PAD_PULLUP = pull_sel & {8{~I_SRST}};
  assign O_PAD_OE_N = ~(drive_en & {8{~I_SRST}});
  assign O_PAD_OUT = drive_val;
  assign O_RAW_DIGITAL_IN = clamped_in;
  assign O_ANALOG_PAD_LINK = I_PAD_IN;
  assign O_IRQ = |(status_q & mask_q);

  // Next values of the port registers.
  assign latch_d = latch_toggled;
  assign dir_d = wsel_dir ? merge_byte(dir_q, wbyte0, wstrb_q[0]) : dir_q;
  assign pud_d = wsel_mcu & wstrb_q[0] ? wbyte0[`PPOL_PUD_BIT] : pud_q;
  assign mask_d = wsel_mask ? merge_byte(mask_q, wbyte0, wstrb_q[0]) : mask_q;
  assign sense_d = wsel_sense ?
                   {merge_byte(sense_q[15:8], wbyte1, wstrb_q[1]),
                    merge_byte(sense_q[7:0], wbyte0, wstrb_q[0])} : sense_q;

  // Status bits: a new event wins over a write-one clear in the same cycle.
  wire [7:0] stat_clear = wsel_stat & wstrb_q[0] ? wbyte0 : 8'h00;
  assign status_d = (status_q & ~stat_clear) | pin_event;

  // Read data selection.
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (I_ARADDR)
      `PPOL_OFS_LATCH: rd_word = {24'h00_0000, latch_q};
      `PPOL_OFS_DIR: rd_word = {24'h00_0000, dir_q};
      `PPOL_OFS_PIN: rd_word = {24'h00_0000, pin_input_reg};
      `PPOL_OFS_MCU: rd_word = {27'h000_0000, pud_q, 4'h0};
      `PPOL_OFS_STAT: rd_word = {24'h00_0000, status_q};
      `PPOL_OFS_MASK: rd_word = {24'h00_0000, mask_q};
      `PPOL_OFS_SENSE: rd_word = {16'h0000, sense_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Pin synchroniser feeding the pin register.
  ppol_sync u_sync (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_d(clamped_in),
    .o_q(pin_input_reg)
  );

  // Port registers.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      latch_q <= `PPOL_RST_BYTE;
      dir_q <= `PPOL_RST_BYTE;
      pud_q <= 1'b0;
      mask_q <= `PPOL_RST_BYTE;
      sense_q <= `PPOL_RST_SENSE;
      status_q <= `PPOL_RST_BYTE;
      pin_prev_q <= `PPOL_RST_BYTE;
    end else begin
      latch_q <= latch_d;
      dir_q <= dir_d;
      pud_q <= pud_d;
      mask_q <= mask_d;
      sense_q <= sense_d;
      status_q <= status_d;
      pin_prev_q <= pin_input_reg;
    end
  end

  // Write address and data holding.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PPOL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? `PPOL_RESP_OKAY : `PPOL_RESP_SLVERR;
    end else if (bvalid_q & I_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read response.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PPOL_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? `PPOL_RESP_OKAY : `PPOL_RESP_SLVERR;
    end else if (rvalid_q & I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : ppol_top

// ==== bench/ppol_top_properties.sv ====
// Concurrent checks on the pad, override and read-answer ports of the port pin logic.
// Assumes it is bound into ppol_top by the bind after the module.
`timescale 1ns/1ps
module ppol_top_properties (
  input logic I_REF_CLK,
  input logic I_SRST,
  input logic I_ARVALID,
  input logic O_ARREADY,
  input logic O_RVALID,
  input logic I_SLEEP_CLAMP,
  input logic [7:0] I_PAD_IN,
  input logic [7:0] O_PAD_OUT,
  input logic [7:0] O_PAD_OE_N,
  input logic [7:0] O_PAD_PULLUP,
  input logic [7:0] O_RAW_DIGITAL_IN,
  input logic [7:0] O_ANALOG_PAD_LINK,
  input logic [7:0] I_PULLUP_OVERRIDE_EN,
  input logic [7:0] I_PULLUP_OVERRIDE_VAL,
  input logic [7:0] I_DIR_OVERRIDE_EN,
  input logic [7:0] I_DIR_OVERRIDE_VAL,
  input logic [7:0] I_OUT_VALUE_OVERRIDE_EN,
  input logic [7:0] I_OUT_VALUE_OVERRIDE_VAL,
  input logic [7:0] I_IN_ENABLE_OVERRIDE_EN,
  input logic [7:0] I_IN_ENABLE_OVERRIDE_VAL
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);
  a_reset_tristate: assert property (disable iff (1'b0) I_SRST |-> O_PAD_OE_N == 8'hFF)
    else $error("pins driven in reset");
  a_reset_pullup_off: assert property (disable iff (1'b0) I_SRST |-> O_PAD_PULLUP == 8'h00)
    else $error("pull-up on in reset");
  a_dir_override: assert property (
    ((~O_PAD_OE_N ^ I_DIR_OVERRIDE_VAL) & I_DIR_OVERRIDE_EN) == 8'h00)
    else $error("drive enable ignores override");
  a_pullup_override: assert property (
    ((O_PAD_PULLUP ^ I_PULLUP_OVERRIDE_VAL) & I_PULLUP_OVERRIDE_EN) == 8'h00)
    else $error("pull-up ignores override");
  a_value_override: assert property (
    ((O_PAD_OUT ^ I_OUT_VALUE_OVERRIDE_VAL) & I_OUT_VALUE_OVERRIDE_EN & ~O_PAD_OE_N) == 8'h00)
    else $error("driven value ignores override");
  a_input_override: assert property (
    ((O_RAW_DIGITAL_IN ^ (I_PAD_IN & I_IN_ENABLE_OVERRIDE_VAL)) &
     I_IN_ENABLE_OVERRIDE_EN) == 8'h00)
    else $error("input enable ignores override");
  a_raw_unsynced: assert property (
    !I_SLEEP_CLAMP |-> ((O_RAW_DIGITAL_IN ^ I_PAD_IN) & ~I_IN_ENABLE_OVERRIDE_EN) == 8'h00)
    else $error("raw input not the pad level");
  a_analog_link: assert property (O_ANALOG_PAD_LINK == I_PAD_IN)
    else $error("analog link differs from pad");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |-> ##1 O_RVALID)
    else $error("read answer late");
  c_clamp_bypass: cover property (I_SLEEP_CLAMP && O_RAW_DIGITAL_IN != 8'h00);
  c_all_pullups: cover property (O_PAD_PULLUP == 8'hFF);
  c_reset_release: cover property (disable iff (1'b0) I_SRST ##1 !I_SRST);
endmodule : ppol_top_properties

bind ppol_top ppol_top_properties u_ppol_top_properties (.*);

// ==== bench/ppol_periph_model.sv ====
// Peripheral stand-in that drives the per-pin override signals of one port.
// Assumes the bench hands it a request word; it answers one clock later.
`timescale 1ns/1ps
module ppol_periph_model (
  input wire logic i_clk,
  input wire logic [71:0] i_req,
  input wire logic [7:0] i_raw,
  output logic [71:0] o_ovr,
  output logic [7:0] o_raw_sync
);
  logic [7:0] raw_meta_q;
  always_ff @(posedge i_clk) begin
    o_ovr <= i_req;
    raw_meta_q <= i_raw;
    o_raw_sync <= raw_meta_q;
  end
endmodule : ppol_periph_model

// ==== bench/ppol_testbench.sv ====
// Self-checking bench of the port pin override logic with an AXI4-Lite master.
// Assumes the design, its header and the peripheral stand-in are compiled first.
`timescale 1ns/1ps
`include "ppol_cfg.svh"
module testbench;
  logic clk, srst, awv, wv, bready, arv, rready, clamp, awr, wr, bv, arr, rvl, irq, global_pullup_disable;
  logic [7:0] awa, ara, ext, lat, dir, msk, pad, raw, oe_n, pout, pull, rsync;
  logic [31:0] wd, rdat, seed;
  logic [71:0] ov, ovr;
  logic [1:0] bresp, rresp;
  int bad_count, checks, cyc;
  assign pad = (~oe_n & pout) | (oe_n & ext);
  ppol_top u_ppol_top (.I_REF_CLK(clk), .I_SRST(srst), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rvl), .I_RREADY(rready),
    .O_IRQ(irq), .I_SLEEP_CLAMP(clamp), .I_PAD_IN(pad), .O_PAD_OUT(pout), .O_PAD_OE_N(oe_n),
    .O_PAD_PULLUP(pull), .O_RAW_DIGITAL_IN(raw), .O_ANALOG_PAD_LINK(),
    .I_PULLUP_OVERRIDE_EN(ovr[7:0]), .I_PULLUP_OVERRIDE_VAL(ovr[15:8]),
    .I_DIR_OVERRIDE_EN(ovr[23:16]), .I_DIR_OVERRIDE_VAL(ovr[31:24]),
    .I_OUT_VALUE_OVERRIDE_EN(ovr[39:32]), .I_OUT_VALUE_OVERRIDE_VAL(ovr[47:40]),
    .I_OUT_TOGGLE_OVERRIDE_EN(ovr[55:48]), .I_IN_ENABLE_OVERRIDE_EN(ovr[63:56]),
    .I_IN_ENABLE_OVERRIDE_VAL(ovr[71:64]));
  ppol_periph_model u_ppol_periph_model (.i_clk(clk), .i_req(ov), .i_raw(raw), .o_ovr(ovr),
    .o_raw_sync(rsync));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rsp;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      rsp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, er});
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rsp;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rvl;
      d = rdat;
      rsp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : rd_reg
  task automatic chk_pins;
    logic [7:0] eoe, epu, eout, ie, eraw;
    repeat (3) @(posedge clk);
    @(negedge clk);
    eoe = ~((ov[23:16] & ov[31:24]) | (~ov[23:16] & dir));
    epu = (ov[7:0] & ov[15:8]) | (~ov[7:0] & ~dir & lat & {8{~global_pullup_disable}});
    eout = (ov[39:32] & ov[47:40]) | (~ov[39:32] & lat);
    ie = (ov[63:56] & ov[71:64]) | (~ov[63:56] & (clamp ? msk : 8'hFF));
    eraw = ((~eoe & eout) | (eoe & ext)) & ie;
    chk({24'h0, oe_n}, {24'h0, eoe});
    chk({24'h0, pull}, {24'h0, epu});
    chk({24'h0, pout | oe_n}, {24'h0, eout | eoe});
    chk({24'h0, raw}, {24'h0, eraw});
    chk({24'h0, rsync}, {24'h0, eraw});
  endtask : chk_pins
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {srst, awv, wv, bready, arv, rready, clamp, global_pullup_disable} = 8'hFF ^ 8'h7F;
    {awa, ara, ext, lat, dir, msk} = 48'h0;
    {wd, ov, bad_count, checks, cyc} = 0;
    seed = 32'h0001_6E11;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    wr_reg(`PPOL_OFS_LATCH, 32'hFF, `PPOL_RESP_OKAY);
    lat = 8'hFF;
    chk_pins();
    @(posedge clk);
    srst <= 1'b1;
    @(negedge clk);
    chk({24'h0, pull}, 32'h0);
    chk({24'h0, oe_n}, 32'hFF);
    @(posedge clk);
    srst <= 1'b0;
    lat = 8'h00;
    $display("test reset done");
    wr_reg(`PPOL_OFS_DIR, 32'hF0, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_LATCH, 32'hA5, `PPOL_RESP_OKAY);
    {dir, lat} = 16'hF0A5;
    chk_pins();
    wr_reg(`PPOL_OFS_MCU, 32'h10, `PPOL_RESP_OKAY);
    global_pullup_disable = 1'b1;
    chk_pins();
    rd_reg(`PPOL_OFS_MCU, 32'h10, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_MCU, 32'h00, `PPOL_RESP_OKAY);
    global_pullup_disable = 1'b0;
    ov <= 72'h3C << 48;
    @(posedge clk);
    ov <= 72'h0;
    rd_reg(`PPOL_OFS_LATCH, 32'h99, `PPOL_RESP_OKAY);
    $display("test pin modes done");
    wr_reg(`PPOL_OFS_MASK, seed[7:0], `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_LATCH, 32'h99, `PPOL_RESP_OKAY);
    {msk, lat} = {seed[7:0], 8'h99};
    repeat (24) begin
      @(posedge clk);
      seed = lfsr(seed);
      ov[31:0] <= seed;
      {ext, clamp} <= {seed[15:8], seed[3]};
      seed = lfsr(seed);
      ov[71:32] <= {seed[7:0], seed[31:24], 8'h00, seed[23:8]};
      chk_pins();
    end
    $display("test random overrides done");
    @(posedge clk);
    {ov, ext, clamp} <= {72'h0, 8'hFF, 1'b0};
    wr_reg(`PPOL_OFS_DIR, 32'h00, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_MASK, 32'h01, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_SENSE, 32'h0C, `PPOL_RESP_OKAY);
    {dir, msk} = 16'h0001;
    clamp <= 1'b1;
    chk_pins();
    wr_reg(`PPOL_OFS_STAT, 32'hFF, `PPOL_RESP_OKAY);
    clamp <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(`PPOL_OFS_STAT, 32'h02, `PPOL_RESP_OKAY);
    rd_reg(`PPOL_OFS_PIN, 32'hFF, `PPOL_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`PPOL_OFS_MASK, 32'h03, `PPOL_RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`PPOL_OFS_STAT, 32'h02, `PPOL_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`PPOL_OFS_SENSE, 32'h60, `PPOL_RESP_OKAY);
    clamp <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`PPOL_OFS_STAT, 32'h0C, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_STAT, 32'hFF, `PPOL_RESP_OKAY);
    clamp <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(`PPOL_OFS_STAT, 32'h08, `PPOL_RESP_OKAY);
    wr_reg(`PPOL_OFS_PIN, 32'h0F, `PPOL_RESP_OKAY);
    rd_reg(`PPOL_OFS_LATCH, 32'h96, `PPOL_RESP_OKAY);
    wr_reg(8'h40, 32'h5A, `PPOL_RESP_SLVERR);
    rd_reg(8'h40, 32'h0, `PPOL_RESP_SLVERR);
    $display("test sleep clamp done");
    end_of_test();
  end
endmodule : testbench
